// >>> design/lms_loop_mode.sv
// Summary of operation
// - Holdover bit, default zero, forces the device into holdover.
// - In forced holdover with history, oscillator uses the history tuning word.
// - In forced holdover without history, oscillator uses the free run word.
// - Forced holdover holds phase and frequency lock detectors unlocked.
// - Free run bit, default zero, forces free run from the free run word.
// - Free run wins over holdover when both bits are set.
// - Mode field code 000 default automatic revertive, 001 automatic nonrevertive.
// - Mode code 010 is manual selection with automatic fallback.
// - Code 011 manual with auto holdover, 100 fully manual without.
// - Manual reference field applies only in the three manual modes.
// - Manual reference 00 A, 01 B, 10 C, 11 D.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
module lms_loop_mode (
    input  wire logic                   i_clk,
    input  wire logic                   i_arst_n,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic            [13:0] paddr,
    input  wire logic            [31:0] pwdata,
    input  wire logic             [3:0] pstrb,
    output logic                 [31:0] prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic                   i_history_valid,
    input  wire logic                   i_phase_locked,
    input  wire logic                   i_freq_locked,
    output lms_pkg::lms_sel_t           o_sel,
    output logic                        o_phase_locked,
    output logic                        o_freq_locked
);
    import lms_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    logic [7:0]    loop_mode_control;
    logic [1:0]    hist_sync;
    logic [1:0]    plock_sync;
    logic [1:0]    flock_sync;
    logic          access;
    logic          hit_ctrl;
    logic          hit_stat;
    lms_swmode_t   swmode;
    logic          man_valid;
    lms_ref_t      man_ref;
    lms_twsrc_t    tw_src;
    logic          force_unlock;
    lms_sel_t      next_sel;

    assign access   = psel && penable;
    assign hit_ctrl = paddr == LMS_LOOP_MODE_ADDR;
    assign hit_stat = paddr == LMS_STATUS_ADDR;
    assign pready   = 1'b1;
    // Unmapped addresses answer with an error rather than silently aliasing.
    assign pslverr  = access && !hit_ctrl && !hit_stat;

    ////////////////////////////////////////////////////////////////////////////
    // Reserved bit 7 is not stored and always reads zero.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            loop_mode_control <= LMS_LOOP_MODE_RESET;
        end else if (access && pwrite && hit_ctrl && pstrb[0]) begin
            loop_mode_control <= {1'b0, pwdata[6:0]};
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            if (hit_ctrl) begin
                prdata <= {24'h00_0000, loop_mode_control};
            end else if (hit_stat) begin
                prdata <= {22'h00_0000, o_sel};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status inputs come from other domains, so each passes two flops first.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            hist_sync  <= 2'h0;
            plock_sync <= 2'h0;
            flock_sync <= 2'h0;
        end else begin
            hist_sync  <= {hist_sync[0], i_history_valid};
            plock_sync <= {plock_sync[0], i_phase_locked};
            flock_sync <= {flock_sync[0], i_freq_locked};
        end
    end

    lms_mode_decode u_decode (
        .i_swmode_raw (loop_mode_control[LMS_SWMODE_HI:LMS_SWMODE_LO]),
        .i_manref_raw (loop_mode_control[LMS_MANREF_HI:LMS_MANREF_LO]),
        .o_swmode     (swmode),
        .o_man_valid  (man_valid),
        .o_man_ref    (man_ref)
    );

    lms_tw_select u_tw (
        .i_holdover      (loop_mode_control[LMS_HOLDOVER_BIT]),
        .i_freerun       (loop_mode_control[LMS_FREERUN_BIT]),
        .i_history_valid (hist_sync[1]),
        .o_tw_src        (tw_src),
        .o_force_unlock  (force_unlock)
    );

    always_comb begin
        next_sel.tw_src       = tw_src;
        next_sel.force_unlock = force_unlock;
        next_sel.swmode       = swmode;
        next_sel.man_valid    = man_valid;
        next_sel.man_ref      = man_valid ? man_ref : LMS_REF_A;
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_sel          <= '{tw_src: LMS_TW_LOOP, force_unlock: 1'b0,
                                swmode: LMS_SW_AUTO_REVERT, man_valid: 1'b0,
                                man_ref: LMS_REF_A};
            o_phase_locked <= 1'b0;
            o_freq_locked  <= 1'b0;
        end else begin
            o_sel          <= next_sel;
            o_phase_locked <= plock_sync[1] && !force_unlock;
            o_freq_locked  <= flock_sync[1] && !force_unlock;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    property p_holdover_hist;
        @(posedge i_clk) disable iff (!i_arst_n)
        (loop_mode_control[6] && !loop_mode_control[5] && hist_sync[1])
            |=> (o_sel.tw_src == LMS_TW_HISTORY);
    endproperty
    a_holdover_hist: assert property (p_holdover_hist)
        else $error("History word not used.");

    property p_holdover_nohist;
        @(posedge i_clk) disable iff (!i_arst_n)
        (loop_mode_control[6] && !hist_sync[1]) |=> (o_sel.tw_src == LMS_TW_FREERUN);
    endproperty
    a_holdover_nohist: assert property (p_holdover_nohist)
        else $error("Free run word not used.");

    property p_unlock;
        @(posedge i_clk) disable iff (!i_arst_n)
        (loop_mode_control[6] && !loop_mode_control[5]) |=> (!o_phase_locked && !o_freq_locked);
    endproperty
    a_unlock: assert property (p_unlock)
        else $error("Lock shown in holdover.");

    property p_freerun;
        @(posedge i_clk) disable iff (!i_arst_n)
        loop_mode_control[5] |=> (o_sel.tw_src == LMS_TW_FREERUN && !o_sel.force_unlock);
    endproperty
    a_freerun: assert property (p_freerun)
        else $error("Free run not given priority.");

    property p_holdover_enters;
        @(posedge i_clk) disable iff (!i_arst_n)
        $rose(loop_mode_control[6]) && !loop_mode_control[5] |=> o_sel.force_unlock;
    endproperty
    a_holdover_enters: assert property (p_holdover_enters)
        else $error("Holdover not entered.");

    property p_write_freerun;
        @(posedge i_clk) disable iff (!i_arst_n)
        (access && pwrite && hit_ctrl && pstrb[0] && pwdata[5])
            |=> ##1 (o_sel.tw_src == LMS_TW_FREERUN);
    endproperty
    a_write_freerun: assert property (p_write_freerun)
        else $error("Write did not force free run.");

    property p_mode_map;
        @(posedge i_clk) disable iff (!i_arst_n)
        1'b1 |=> (o_sel.swmode == (($past(loop_mode_control[4:2]) > 3'h4) ?
                  LMS_SW_AUTO_REVERT : lms_swmode_t'($past(loop_mode_control[4:2]))));
    endproperty
    a_mode_map: assert property (p_mode_map)
        else $error("Switchover mode wrong.");

    property p_man_ref;
        @(posedge i_clk) disable iff (!i_arst_n)
        (loop_mode_control[4:2] inside {3'h2, 3'h3, 3'h4})
            |=> (o_sel.man_valid && o_sel.man_ref == $past(loop_mode_control[1:0]));
    endproperty
    a_man_ref: assert property (p_man_ref)
        else $error("Manual reference wrong.");

    property p_auto_noman;
        @(posedge i_clk) disable iff (!i_arst_n)
        !(loop_mode_control[4:2] inside {3'h2, 3'h3, 3'h4}) |=> !o_sel.man_valid;
    endproperty
    a_auto_noman: assert property (p_auto_noman)
        else $error("Manual reference in auto mode.");

    property p_no_hist_unforced;
        @(posedge i_clk) disable iff (!i_arst_n)
        !(loop_mode_control[LMS_HOLDOVER_BIT] && !loop_mode_control[LMS_FREERUN_BIT]
          && hist_sync[1]) |=> (o_sel.tw_src != LMS_TW_HISTORY);
    endproperty
    a_no_hist_unforced: assert property (p_no_hist_unforced)
        else $error("History word used without forced holdover.");

    property p_loop_unforced;
        @(posedge i_clk) disable iff (!i_arst_n)
        (!loop_mode_control[LMS_HOLDOVER_BIT] && !loop_mode_control[LMS_FREERUN_BIT])
            |=> (o_sel.tw_src == LMS_TW_LOOP);
    endproperty
    a_loop_unforced: assert property (p_loop_unforced)
        else $error("Loop word not used while nothing is forced.");

    property p_no_unlock_unforced;
        @(posedge i_clk) disable iff (!i_arst_n)
        !(loop_mode_control[LMS_HOLDOVER_BIT] && !loop_mode_control[LMS_FREERUN_BIT])
            |=> !o_sel.force_unlock;
    endproperty
    a_no_unlock_unforced: assert property (p_no_unlock_unforced)
        else $error("Detectors held unlocked without forced holdover.");

    // Outside forced holdover the synchronised detector levels pass straight through.
    property p_lock_pass;
        @(posedge i_clk) disable iff (!i_arst_n)
        (!loop_mode_control[LMS_HOLDOVER_BIT] || loop_mode_control[LMS_FREERUN_BIT])
            |=> (o_phase_locked == $past(plock_sync[1]) &&
                 o_freq_locked == $past(flock_sync[1]));
    endproperty
    a_lock_pass: assert property (p_lock_pass)
        else $error("Lock levels not passed through.");

    property p_nonrevert;
        @(posedge i_clk) disable iff (!i_arst_n)
        (loop_mode_control[LMS_SWMODE_HI:LMS_SWMODE_LO] == 3'h1)
            |=> (o_sel.swmode == LMS_SW_AUTO_NONREVERT);
    endproperty
    a_nonrevert: assert property (p_nonrevert)
        else $error("Nonrevertive mode not selected.");

    property p_fallback;
        @(posedge i_clk) disable iff (!i_arst_n)
        (loop_mode_control[LMS_SWMODE_HI:LMS_SWMODE_LO] == 3'h2)
            |=> (o_sel.swmode == LMS_SW_MAN_FALLBACK);
    endproperty
    a_fallback: assert property (p_fallback)
        else $error("Manual fallback mode not selected.");

    property p_autohold;
        @(posedge i_clk) disable iff (!i_arst_n)
        (loop_mode_control[LMS_SWMODE_HI:LMS_SWMODE_LO] == 3'h3)
            |=> (o_sel.swmode == LMS_SW_MAN_AUTOHOLD);
    endproperty
    a_autohold: assert property (p_autohold)
        else $error("Manual auto holdover mode not selected.");

    property p_full_manual;
        @(posedge i_clk) disable iff (!i_arst_n)
        (loop_mode_control[LMS_SWMODE_HI:LMS_SWMODE_LO] == 3'h4)
            |=> (o_sel.swmode == LMS_SW_FULL_MANUAL);
    endproperty
    a_full_manual: assert property (p_full_manual)
        else $error("Full manual mode not selected.");

    property p_unused_code;
        @(posedge i_clk) disable iff (!i_arst_n)
        (loop_mode_control[LMS_SWMODE_HI:LMS_SWMODE_LO] inside {3'h5, 3'h6, 3'h7})
            |=> (o_sel.swmode == LMS_SW_AUTO_REVERT && !o_sel.man_valid);
    endproperty
    a_unused_code: assert property (p_unused_code)
        else $error("Unused mode code not treated as revertive.");

    property p_write_lands;
        @(posedge i_clk) disable iff (!i_arst_n)
        (access && pwrite && hit_ctrl && pstrb[0])
            |=> (loop_mode_control == {1'b0, $past(pwdata[6:0])});
    endproperty
    a_write_lands: assert property (p_write_lands)
        else $error("Register write did not land.");

    property p_strobe_off;
        @(posedge i_clk) disable iff (!i_arst_n)
        (access && pwrite && hit_ctrl && !pstrb[0]) |=> $stable(loop_mode_control);
    endproperty
    a_strobe_off: assert property (p_strobe_off)
        else $error("Write without byte strobe changed the register.");

    property p_read_ctrl;
        @(posedge i_clk) disable iff (!i_arst_n)
        (psel && !penable && !pwrite && hit_ctrl)
            |=> (prdata == {24'h00_0000, $past(loop_mode_control)});
    endproperty
    a_read_ctrl: assert property (p_read_ctrl)
        else $error("Control register read data wrong.");

    property p_read_stat;
        @(posedge i_clk) disable iff (!i_arst_n)
        (psel && !penable && !pwrite && hit_stat)
            |=> (prdata == {22'h00_0000, $past(o_sel)});
    endproperty
    a_read_stat: assert property (p_read_stat)
        else $error("Status read data wrong.");

    property p_read_unmapped;
        @(posedge i_clk) disable iff (!i_arst_n)
        (psel && !penable && !pwrite && !hit_ctrl && !hit_stat) |=> (prdata == 32'h0000_0000);
    endproperty
    a_read_unmapped: assert property (p_read_unmapped)
        else $error("Unmapped read data not zero.");

    c_holdover_hist: cover property (@(posedge i_clk) o_sel.tw_src == LMS_TW_HISTORY);
    c_status_read: cover property (@(posedge i_clk) access && !pwrite && hit_stat);
    c_both_set: cover property (@(posedge i_clk) loop_mode_control[6:5] == 2'h3);
    c_manual_d: cover property (@(posedge i_clk) o_sel.man_valid && o_sel.man_ref == LMS_REF_D);
    c_bad_addr: cover property (@(posedge i_clk) pslverr);

endmodule // lms_loop_mode

// >>> design/lms_mode_decode.sv
`timescale 1ns/1ps
module lms_mode_decode (
    input  wire logic             [2:0] i_swmode_raw,
    input  wire logic             [1:0] i_manref_raw,
    output lms_pkg::lms_swmode_t        o_swmode,
    output logic                        o_man_valid,
    output lms_pkg::lms_ref_t           o_man_ref
);
    import lms_pkg::*;

    always_comb begin
        case (i_swmode_raw)
            3'h0: o_swmode = LMS_SW_AUTO_REVERT;
            3'h1: o_swmode = LMS_SW_AUTO_NONREVERT;
            3'h2: o_swmode = LMS_SW_MAN_FALLBACK;
            3'h3: o_swmode = LMS_SW_MAN_AUTOHOLD;
            3'h4: o_swmode = LMS_SW_FULL_MANUAL;
            // Unused codes fall back to the safest automatic mode.
            default: o_swmode = LMS_SW_AUTO_REVERT;
        endcase
    end

    // Manual reference only matters in the three manual modes.
    assign o_man_valid = (o_swmode == LMS_SW_MAN_FALLBACK) ||
                         (o_swmode == LMS_SW_MAN_AUTOHOLD) ||
                         (o_swmode == LMS_SW_FULL_MANUAL);
    assign o_man_ref   = lms_ref_t'(i_manref_raw);

endmodule // lms_mode_decode

// >>> design/lms_pkg.sv
package lms_pkg;

    localparam logic [11:0] LMS_LOOP_MODE_OFFSET = 12'ha01;
    localparam logic [13:0] LMS_LOOP_MODE_ADDR   = 14'h2804;
    localparam logic [13:0] LMS_STATUS_ADDR      = 14'h2808;
    localparam logic [7:0]  LMS_LOOP_MODE_RESET  = 8'h00;

    localparam int LMS_HOLDOVER_BIT = 6;
    localparam int LMS_FREERUN_BIT  = 5;
    localparam int LMS_SWMODE_HI    = 4;
    localparam int LMS_SWMODE_LO    = 2;
    localparam int LMS_MANREF_HI    = 1;
    localparam int LMS_MANREF_LO    = 0;

    typedef enum logic [2:0] {
        LMS_SW_AUTO_REVERT    = 3'h0,
        LMS_SW_AUTO_NONREVERT = 3'h1,
        LMS_SW_MAN_FALLBACK   = 3'h2,
        LMS_SW_MAN_AUTOHOLD   = 3'h3,
        LMS_SW_FULL_MANUAL    = 3'h4
    } lms_swmode_t;

    typedef enum logic [1:0] {
        LMS_REF_A = 2'h0,
        LMS_REF_B = 2'h1,
        LMS_REF_C = 2'h2,
        LMS_REF_D = 2'h3
    } lms_ref_t;

    typedef enum logic [2:0] {
        LMS_TW_LOOP    = 3'h1,
        LMS_TW_HISTORY = 3'h2,
        LMS_TW_FREERUN = 3'h4
    } lms_twsrc_t;

    typedef struct packed {
        logic        holdover;
        logic        freerun;
        lms_swmode_t swmode;
        lms_ref_t    manref;
    } lms_ctrl_t;

    typedef struct packed {
        lms_twsrc_t  tw_src;
        logic        force_unlock;
        lms_swmode_t swmode;
        logic        man_valid;
        lms_ref_t    man_ref;
    } lms_sel_t;

endpackage

// >>> design/lms_tw_select.sv
`timescale 1ns/1ps
module lms_tw_select (
    input  wire logic             i_holdover,
    input  wire logic             i_freerun,
    input  wire logic             i_history_valid,
    output lms_pkg::lms_twsrc_t   o_tw_src,
    output logic                  o_force_unlock
);
    import lms_pkg::*;

    always_comb begin
        if (i_freerun) begin
            o_tw_src = LMS_TW_FREERUN;
        end else if (i_holdover && i_history_valid) begin
            o_tw_src = LMS_TW_HISTORY;
        end else if (i_holdover) begin
            o_tw_src = LMS_TW_FREERUN;
        end else begin
            o_tw_src = LMS_TW_LOOP;
        end
    end

    // Free run overrides holdover, so the detectors are only held when holdover is set without free run.
    assign o_force_unlock = i_holdover && !i_freerun;

endmodule // lms_tw_select

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
    $display("BAD t=%0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
    import lms_pkg::*;
    logic              i_clk = 1'b0;
    logic              i_arst_n = 1'b0;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic       [13:0] paddr = 14'h0000;
    logic       [31:0] pwdata = 32'h00000000;
    logic        [3:0] pstrb = 4'h0;
    logic       [31:0] prdata;
    logic              pready;
    logic              pslverr;
    logic              i_history_valid = 1'b0;
    logic              i_phase_locked = 1'b0;
    logic              i_freq_locked = 1'b0;
    lms_sel_t          o_sel;
    logic              o_phase_locked;
    logic              o_freq_locked;
    int                n_fail = 0;
    int                n_tests = 0;
    int                i;
    logic       [31:0] q;
    logic              e;
    logic        [7:0] r;
    lms_sel_t          s;
    ////////////////////////////////////////////////////////////////////////////////////////////
    lms_loop_mode uut (.i_clk(i_clk), .i_arst_n(i_arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .i_history_valid(i_history_valid),
        .i_phase_locked(i_phase_locked), .i_freq_locked(i_freq_locked), .o_sel(o_sel),
        .o_phase_locked(o_phase_locked), .o_freq_locked(o_freq_locked));
    always #50 i_clk = ~i_clk;
    ////////////////////////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // The slave answer time is not assumed; a wait that runs out ends the run.
    task automatic apb(input logic wr, input logic [13:0] a, input logic [31:0] d,
                       input logic [3:0] st, output logic [31:0] rd, output logic er);
        int k;
        @(posedge i_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= st;
        @(posedge i_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge i_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            n_fail++;
            $display("BAD t=%0t no answer from slave", $time);
            test_done();
        end else begin
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    function automatic lms_sel_t exp_sel(input logic [7:0] v, input logic h);
        lms_sel_t x;
        x.force_unlock = v[6] & ~v[5];
        if (v[5]) begin
            x.tw_src = LMS_TW_FREERUN;
        end else if (v[6]) begin
            x.tw_src = h ? LMS_TW_HISTORY : LMS_TW_FREERUN;
        end else begin
            x.tw_src = LMS_TW_LOOP;
        end
        x.swmode = (v[4:2] <= 3'h4) ? lms_swmode_t'(v[4:2]) : LMS_SW_AUTO_REVERT;
        x.man_valid = (v[4:2] >= 3'h2) && (v[4:2] <= 3'h4);
        x.man_ref = x.man_valid ? lms_ref_t'(v[1:0]) : LMS_REF_A;
        return x;
    endfunction
    ////////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge i_clk);
        i_arst_n <= 1'b1;
        `CHK(o_sel, exp_sel(8'h00, 1'b0))
        apb(1'b0, LMS_LOOP_MODE_ADDR, 32'h0, 4'hf, q, e);
        `CHK(q, 32'h00000000)
        apb(1'b1, 14'h2800, 32'h00000060, 4'hf, q, e);
        `CHK(e, 1'b1)
        apb(1'b1, LMS_LOOP_MODE_ADDR, 32'h00000040, 4'h0, q, e);
        apb(1'b0, LMS_LOOP_MODE_ADDR, 32'h0, 4'hf, q, e);
        `CHK(q, 32'h00000000)
        // Every mix of holdover, free run and history; the detectors report opposite levels.
        for (i = 0; i < 8; i++) begin
            r = {1'b0, i[2], i[1], 5'h00};
            i_history_valid <= i[0];
            i_phase_locked <= i[0];
            i_freq_locked <= ~i[0];
            apb(1'b1, LMS_LOOP_MODE_ADDR, {24'h0, r}, 4'hf, q, e);
            repeat (4) @(posedge i_clk);
            s = exp_sel(r, i[0]);
            `CHK(o_sel.tw_src, s.tw_src)
            `CHK(o_sel.force_unlock, s.force_unlock)
            `CHK(o_phase_locked, i[0] & ~s.force_unlock)
            `CHK(o_freq_locked, ~i[0] & ~s.force_unlock)
            apb(1'b0, LMS_STATUS_ADDR, 32'h0, 4'hf, q, e);
            `CHK(q, {22'h0, s})
            `CHK(e, 1'b0)
        end
        // All mode codes with all references; odd steps also set the reserved top bit.
        for (i = 0; i < 32; i++) begin
            r = {i[0], 2'b00, i[4:0]};
            apb(1'b1, LMS_LOOP_MODE_ADDR, {24'h0, r}, 4'hf, q, e);
            repeat (2) @(posedge i_clk);
            s = exp_sel(r, i[0]);
            `CHK(o_sel.swmode, s.swmode)
            `CHK(o_sel.man_valid, s.man_valid)
            `CHK(o_sel.man_ref, s.man_ref)
            apb(1'b0, LMS_LOOP_MODE_ADDR, 32'h0, 4'hf, q, e);
            `CHK(q, {25'h0, r[6:0]})
        end
        apb(1'b0, 14'h2800, 32'h0, 4'hf, q, e);
        `CHK(e, 1'b1)
        `CHK(q, 32'h00000000)
        // A second reset in mid-run must bring back the defaults.
        apb(1'b1, LMS_LOOP_MODE_ADDR, 32'h00000073, 4'hf, q, e);
        @(posedge i_clk);
        i_arst_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_arst_n <= 1'b1;
        apb(1'b0, LMS_LOOP_MODE_ADDR, 32'h0, 4'hf, q, e);
        `CHK(q, 32'h00000000)
        `CHK(o_sel, exp_sel(8'h00, 1'b0))
        test_done();
    end
endmodule // tb_top
